// file: hdl/nvm_table_access_control.v
/*
 * Nonvolatile memory controller: program flash, user IDs, configuration,
 * data EEPROM, table read/write path, unlock, timed self-programming,
 * programmer port with protection and bulk erase.
 * Assumes core strobes on clk; programmer pins asynchronous.
 */
`timescale 1ns/10ps
`include "nvm_defs.vh"

module nvm_table_access_control #(
	parameter [15:0] DEV_ID = 16'h5a5a, // Arbitrary value
	parameter [15:0] REV_ID = 16'h0101  // Arbitrary value
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Register port
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// Table operations
	input  wire        table_read_op,
	input  wire        table_write_op,
	input  wire [1:0]  tbl_mode,
	// Instruction fetch
	input  wire [15:0] fetch_addr,
	output reg  [15:0] fetch_data,
	output wire        fetch_hold,
	// External programmer
	input  wire        prog_en,
	input  wire [21:0] prog_addr,
	input  wire [7:0]  prog_wdata,
	input  wire        prog_wr,
	input  wire        prog_rd,
	input  wire        prog_bulk,
	output reg  [7:0]  prog_rdata
);

	/*********************************************************************
	 * Storage and state
	 *********************************************************************/
	localparam [1:0] S_IDLE   = 2'd0;
	localparam [1:0] S_COMMIT = 2'd1;
	localparam [1:0] S_WAIT   = 2'd2;
	localparam [1:0] S_BULK   = 2'd3;

	reg  [15:0] pfm_mem [0:65535];
	reg  [7:0]  ee_mem  [0:1023];
	reg  [7:0]  uid_mem [0:15];
	reg  [7:0]  cfg_mem [0:11];

	reg  [7:0]  ctl_ff;
	reg  [1:0]  key_ff;
	reg  [7:0]  table_latch_ff;
	reg  [21:0] table_pointer_ff;
	reg  [7:0]  nvm_data_ff;
	reg  [9:0]  ee_addr_ff;
	reg         done_ff;
	reg  [1:0]  state_ff;
	reg  [15:0] cnt_ff;
	reg         erase_ff;
	reg  [3:0]  sync1_ff;
	reg  [3:0]  sync2_ff;
	reg  [3:0]  sync3_ff;
	reg  [21:0] addr_s1_ff;
	reg  [21:0] addr_s2_ff;
	reg  [7:0]  wdat_s1_ff;
	reg  [7:0]  wdat_s2_ff;
	integer     i;

	wire [1:0]  region_select = ctl_ff[`NVM_CTL_REGION_LO +: 2];
	wire        code_protect  = ~cfg_mem[`NVM_CFG_CP_IDX][`NVM_CP_BIT];
	wire        data_protect  = ~cfg_mem[`NVM_CFG_CP_IDX][`NVM_CPD_BIT];
	wire [3:0]  self_program_lock = ~cfg_mem[`NVM_CFG_WRT_IDX][3:0];

	/*********************************************************************
	 * Address functions
	 *********************************************************************/
	function in_rng;
		input [21:0] a;
		input [21:0] lo;
		input [21:0] hi;
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	function [21:0] step_ptr;
		input [21:0] p;
		input        down;
		step_ptr = down ? {p[21], p[20:0] - 21'd1} : {p[21], p[20:0] + 21'd1};
	endfunction

	function [7:0] space_byte;
		input [21:0] a;
		reg   [15:0] w;
		begin
			w = pfm_mem[a[16:1]];
			space_byte = 8'h00;
			if (in_rng(a, 22'h000000, `NVM_PFM_LAST))
				space_byte = a[0] ? w[15:8] : w[7:0];
			else if (in_rng(a, `NVM_UID_FIRST, `NVM_UID_LAST))
				space_byte = uid_mem[a[3:0]];
			else if (in_rng(a, `NVM_CFG_FIRST, `NVM_CFG_LAST))
				space_byte = cfg_mem[a[3:0]];
			else if (in_rng(a, `NVM_EE_FIRST, `NVM_EE_LAST))
				space_byte = ee_mem[a[9:0]];
			else if (a >= `NVM_ID_FIRST)
				case (a[1:0])
					2'd0: space_byte = REV_ID[7:0];
					2'd1: space_byte = REV_ID[15:8];
					2'd2: space_byte = DEV_ID[7:0];
					default: space_byte = DEV_ID[15:8];
				endcase
		end
	endfunction

	/*********************************************************************
	 * Programmer pin synchronisers
	 *********************************************************************/
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
			sync3_ff <= 4'h0;
			addr_s1_ff <= 22'h000000;
			addr_s2_ff <= 22'h000000;
			wdat_s1_ff <= 8'h00;
			wdat_s2_ff <= 8'h00;
		end else begin
			sync1_ff <= {prog_en, prog_bulk, prog_wr, prog_rd};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			addr_s1_ff <= prog_addr;
			addr_s2_ff <= addr_s1_ff;
			wdat_s1_ff <= prog_wdata;
			wdat_s2_ff <= wdat_s1_ff;
		end
	end

	wire pen      = sync2_ff[3];
	wire p_idle   = pen && (state_ff == S_IDLE);
	wire p_bulk   = p_idle && sync2_ff[2] && !sync3_ff[2];
	wire p_wr     = p_idle && sync2_ff[1] && !sync3_ff[1];
	wire p_rd     = pen && sync2_ff[0] && !sync3_ff[0];
	wire p_pfm    = in_rng(addr_s2_ff, 22'h000000, `NVM_PFM_LAST);
	wire p_ee     = in_rng(addr_s2_ff, `NVM_EE_FIRST, `NVM_EE_LAST);
	wire p_block  = (p_pfm && code_protect) || (p_ee && data_protect);

	/*********************************************************************
	 * Table path
	 *********************************************************************/
	wire [21:0] pre_ptr = step_ptr(table_pointer_ff, 1'b0);
	wire [21:0] op_ptr  = (tbl_mode == 2'd3) ? pre_ptr : table_pointer_ff;
	wire        tp_pfm  = in_rng(op_ptr, 22'h000000, `NVM_PFM_LAST);
	wire        tp_x1   = in_rng(op_ptr, `NVM_UID_FIRST, `NVM_UID_LAST) ||
		in_rng(op_ptr, `NVM_CFG_FIRST, `NVM_CFG_LAST) || (op_ptr >= `NVM_ID_FIRST);
	wire        tbl_ok  = (region_select == `NVM_REGION_PFM) ? tp_pfm :
		(region_select[0] ? tp_x1 : 1'b0);
	wire        tbl_go  = (table_read_op || table_write_op) && (state_ff == S_IDLE);
	wire        latch_we = table_write_op && (state_ff == S_IDLE) &&
		(region_select != `NVM_REGION_EE);

	/*********************************************************************
	 * Start decode
	 *********************************************************************/
	wire        ctl_wr   = reg_wr && (reg_addr == `NVM_REG_CONTROL);
	wire [1:0]  new_reg  = reg_wdata[`NVM_CTL_REGION_LO +: 2];
	wire        start_rq = ctl_wr && reg_wdata[`NVM_CTL_START] &&
		!ctl_ff[`NVM_CTL_START] && (state_ff == S_IDLE);
	wire        unlocked = (key_ff == 2'd2) && ctl_ff[`NVM_CTL_WREN];
	wire        sp_pfm   = in_rng(table_pointer_ff, 22'h000000, `NVM_PFM_LAST);
	wire        sp_uid   = in_rng(table_pointer_ff, `NVM_UID_FIRST, `NVM_UID_LAST);
	wire        sp_cfg   = in_rng(table_pointer_ff, `NVM_CFG_FIRST, `NVM_CFG_LAST);
	wire        sp_lock  = self_program_lock[table_pointer_ff[16:15]];
	wire        s_ok     = (new_reg == `NVM_REGION_EE) ? 1'b1 :
		(new_reg == `NVM_REGION_PFM) ? (sp_pfm && !sp_lock) :
		(new_reg[0] ? (sp_uid || sp_cfg) : 1'b0);
	wire        s_go     = start_rq && unlocked && s_ok;
	wire        s_fault  = start_rq && unlocked && !s_ok;
	wire        s_pfm    = s_go && (new_reg == `NVM_REGION_PFM);
	wire        expire;
	wire [15:0] latch_word;
	wire        last_word = (cnt_ff[5:0] == (erase_ff ? `NVM_ROW_LAST : `NVM_LATCH_LAST));
	wire [15:0] pfm_word  = erase_ff ? {table_pointer_ff[16:6], cnt_ff[4:0]} :
		{table_pointer_ff[16:7], cnt_ff[5:0]};

	assign fetch_hold = (state_ff != S_IDLE);

	/*********************************************************************
	 * Submodules
	 *********************************************************************/
	nvm_write_latch u_latch (
		.clk      (clk),
		.rst      (rst),
		.wr_en    (latch_we),
		.byte_idx (op_ptr[6:0]),
		.wdata    (table_latch_ff),
		.clr      ((state_ff == S_COMMIT) && last_word && !erase_ff),
		.rd_idx   (cnt_ff[5:0]),
		.rd_word  (latch_word)
	);

	nvm_prog_timer u_timer (
		.clk    (clk),
		.rst    (rst),
		.start  ((state_ff == S_COMMIT && last_word) || (s_go && !s_pfm)),
		.busy   (),
		.expire (expire)
	);

	/*********************************************************************
	 * Control registers and sequencer
	 *********************************************************************/
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_ff           <= `NVM_CTL_RESET;
			key_ff           <= 2'd0;
			table_latch_ff   <= 8'h00;
			table_pointer_ff <= 22'h000000;
			nvm_data_ff      <= 8'h00;
			ee_addr_ff       <= 10'h000;
			done_ff          <= 1'b0;
			state_ff         <= S_IDLE;
			cnt_ff           <= 16'h0000;
			erase_ff         <= 1'b0;
			reg_rdata        <= 8'h00;
			prog_rdata       <= 8'h00;
			fetch_data       <= 16'h0000;
		end else begin
			if (!fetch_hold)
				fetch_data <= pfm_mem[fetch_addr];
			if (p_rd)
				prog_rdata <= p_block ? 8'h00 : space_byte(addr_s2_ff);
			if (reg_wr) begin
				if (reg_addr == `NVM_REG_UNLOCK) begin
					if (reg_wdata == `NVM_KEY_FIRST)
						key_ff <= 2'd1;
					else if (reg_wdata == `NVM_KEY_SECOND && key_ff == 2'd1)
						key_ff <= 2'd2;
					else
						key_ff <= 2'd0;
				end else
					key_ff <= 2'd0;
				case (reg_addr)
					`NVM_REG_LATCH:   table_latch_ff <= reg_wdata;
					`NVM_REG_PTR_L:   table_pointer_ff[7:0] <= reg_wdata;
					`NVM_REG_PTR_H:   table_pointer_ff[15:8] <= reg_wdata;
					`NVM_REG_PTR_U:   table_pointer_ff[21:16] <= reg_wdata[5:0];
					`NVM_REG_DATA:    nvm_data_ff <= reg_wdata;
					`NVM_REG_EEADR_L: ee_addr_ff[7:0] <= reg_wdata;
					`NVM_REG_EEADR_H: ee_addr_ff[9:8] <= reg_wdata[1:0];
					`NVM_REG_STATUS: begin
						if (!reg_wdata[`NVM_STA_DONE])
							done_ff <= 1'b0;
					end
					`NVM_REG_CONTROL: begin
						ctl_ff[7:6] <= reg_wdata[7:6];
						ctl_ff[`NVM_CTL_ERASE] <= reg_wdata[`NVM_CTL_ERASE];
						ctl_ff[`NVM_CTL_WREN]  <= reg_wdata[`NVM_CTL_WREN];
						ctl_ff[`NVM_CTL_FAULT] <= reg_wdata[`NVM_CTL_FAULT] | s_fault;
						if (s_go)
							ctl_ff[`NVM_CTL_START] <= 1'b1;
						if (reg_wdata[`NVM_CTL_EEREAD])
							nvm_data_ff <= (new_reg == `NVM_REGION_EE) ?
								ee_mem[ee_addr_ff] : 8'h00;
					end
					default: ;
				endcase
			end
			if (reg_rd)
				case (reg_addr)
					`NVM_REG_CONTROL: reg_rdata <= ctl_ff;
					`NVM_REG_LATCH:   reg_rdata <= table_latch_ff;
					`NVM_REG_PTR_L:   reg_rdata <= table_pointer_ff[7:0];
					`NVM_REG_PTR_H:   reg_rdata <= table_pointer_ff[15:8];
					`NVM_REG_PTR_U:   reg_rdata <= {2'b00, table_pointer_ff[21:16]};
					`NVM_REG_DATA:    reg_rdata <= nvm_data_ff;
					`NVM_REG_EEADR_L: reg_rdata <= ee_addr_ff[7:0];
					`NVM_REG_EEADR_H: reg_rdata <= {6'h00, ee_addr_ff[9:8]};
					`NVM_REG_STATUS:  reg_rdata <= {6'h00, fetch_hold, done_ff};
					default:          reg_rdata <= 8'h00;
				endcase
			if (tbl_go) begin
				if (table_read_op)
					table_latch_ff <= tbl_ok ? space_byte(op_ptr) : 8'h00;
				case (tbl_mode)
					2'd1:    table_pointer_ff <= pre_ptr;
					2'd2:    table_pointer_ff <= step_ptr(table_pointer_ff, 1'b1);
					2'd3:    table_pointer_ff <= pre_ptr;
					default: ;
				endcase
			end
			case (state_ff)
				S_IDLE: begin
					cnt_ff <= 16'h0000;
					if (p_bulk)
						state_ff <= S_BULK;
					else if (s_pfm) begin
						erase_ff <= reg_wdata[`NVM_CTL_ERASE];
						state_ff <= S_COMMIT;
					end else if (s_go)
						state_ff <= S_WAIT;
				end
				S_COMMIT: begin
					cnt_ff <= cnt_ff + 16'h0001;
					if (last_word)
						state_ff <= S_WAIT;
				end
				S_WAIT: begin
					if (expire) begin
						ctl_ff[`NVM_CTL_START] <= 1'b0;
						ctl_ff[`NVM_CTL_FAULT] <= 1'b0;
						done_ff  <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				default: begin
					cnt_ff <= cnt_ff + 16'h0001;
					if (cnt_ff == `NVM_BULK_LAST)
						state_ff <= S_IDLE;
				end
			endcase
		end
	end

	/*********************************************************************
	 * Array updates
	 *********************************************************************/
	always @(posedge clk) begin
		if (state_ff == S_COMMIT)
			pfm_mem[pfm_word] <= erase_ff ? 16'hffff :
				(pfm_mem[pfm_word] & latch_word);
		else if (state_ff == S_BULK) begin
			pfm_mem[cnt_ff] <= 16'hffff;
			ee_mem[cnt_ff[9:0]] <= 8'hff;
			if (cnt_ff < 16'h0010)
				uid_mem[cnt_ff[3:0]] <= 8'hff;
			if (cnt_ff < 16'h000c)
				cfg_mem[cnt_ff[3:0]] <= 8'hff;
		end else if (s_go && !s_pfm) begin
			if (new_reg == `NVM_REGION_EE)
				ee_mem[ee_addr_ff] <= nvm_data_ff;
			else if (sp_uid)
				uid_mem[table_pointer_ff[3:0]] <= table_latch_ff;
			else
				cfg_mem[table_pointer_ff[3:0]] <= table_latch_ff;
		end else if (p_wr && !p_block) begin
			if (p_pfm) begin
				if (addr_s2_ff[0])
					pfm_mem[addr_s2_ff[16:1]][15:8] <= wdat_s2_ff;
				else
					pfm_mem[addr_s2_ff[16:1]][7:0] <= wdat_s2_ff;
			end else if (p_ee)
				ee_mem[addr_s2_ff[9:0]] <= wdat_s2_ff;
			else if (in_rng(addr_s2_ff, `NVM_UID_FIRST, `NVM_UID_LAST))
				uid_mem[addr_s2_ff[3:0]] <= wdat_s2_ff;
			else if (in_rng(addr_s2_ff, `NVM_CFG_FIRST, `NVM_CFG_LAST))
				cfg_mem[addr_s2_ff[3:0]] <= wdat_s2_ff;
		end
	end

endmodule // nvm_table_access_control

// file: hdl/nvm_defs.vh
/*
 * Constants of the nonvolatile memory access controller: register indexes,
 * field positions, reset values, address map and programming time.
 * Assumes inclusion by bare name from the design files of this block.
 */
// Function
// - Two-bit region select routes every firmware table, write and data read
// - Internal timer ends firmware writes and row erases; bulk erase runs on its own count
// - Fetches held while programming is busy
// - Code protection blocks programmer, not firmware
// - Bulk erase or a programmer or firmware config byte write clears protection
// - Write protection blocks firmware self-programming only
// - Bad region reads zero, write faults
// - Eight unprotected user ID words
// - Flash read bytewise, 00_0000h to 01_FFFFh
// - Block writes only; no firmware bulk erase
// - Flash of 16-bit words in rows
// - Sixty-four word hidden write latches
// - Table read puts byte in table latch
// - Table write fills holding latch only
// - Table operations address any byte
// - Single 8-bit table latch carries data
// - Start bit set by firmware, cleared by hardware
// - Done flag sticky until firmware clears
// - Erase select turns a flash region start into row erase
`ifndef NVM_DEFS_VH
`define NVM_DEFS_VH

/*****************************************************************************
 * Register indexes
 *****************************************************************************/
`define NVM_REG_CONTROL   4'h0
`define NVM_REG_UNLOCK    4'h1
`define NVM_REG_LATCH     4'h2
`define NVM_REG_PTR_L     4'h3
`define NVM_REG_PTR_H     4'h4
`define NVM_REG_PTR_U     4'h5
`define NVM_REG_DATA      4'h6
`define NVM_REG_EEADR_L   4'h7
`define NVM_REG_EEADR_H   4'h8
`define NVM_REG_STATUS    4'h9

/*****************************************************************************
 * Control and status fields
 *****************************************************************************/
`define NVM_CTL_START     0
`define NVM_CTL_WREN      1
`define NVM_CTL_FAULT     2
`define NVM_CTL_ERASE     3
`define NVM_CTL_EEREAD    4
`define NVM_CTL_REGION_LO 6
`define NVM_CTL_RESET     8'h00
`define NVM_STA_DONE      0
`define NVM_STA_BUSY      1
`define NVM_REGION_EE     2'b00
`define NVM_REGION_PFM    2'b10
`define NVM_KEY_FIRST     8'h55
`define NVM_KEY_SECOND    8'haa

/*****************************************************************************
 * Address map
 *****************************************************************************/
`define NVM_PFM_LAST      22'h01ffff
`define NVM_UID_FIRST     22'h200000
`define NVM_UID_LAST      22'h20000f
`define NVM_CFG_FIRST     22'h300000
`define NVM_CFG_LAST      22'h30000b
`define NVM_EE_FIRST      22'h310000
`define NVM_EE_LAST       22'h3103ff
`define NVM_ID_FIRST      22'h3ffffc
`define NVM_LATCH_LAST    6'h3f
`define NVM_ROW_LAST      6'h1f
`define NVM_BULK_LAST     16'hffff
`define NVM_CFG_WRT_IDX   4'h7
`define NVM_CFG_CP_IDX    4'h8
`define NVM_CP_BIT        0
`define NVM_CPD_BIT       1

/*****************************************************************************
 * Programming time
 *****************************************************************************/
`define NVM_CLK_NS        10
`define NVM_PROG_NS       20000
`define NVM_PROG_CYC      ((`NVM_PROG_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)

`endif

// file: hdl/nvm_prog_timer.v
/*
 * Programming timer: one start pulse runs a fixed count of cycles and
 * ends with a one-cycle expiry pulse.
 * Assumes start only while not busy.
 */
`timescale 1ns/10ps
`include "nvm_defs.vh"

module nvm_prog_timer (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Control
	input  wire        start,
	output wire        busy,
	output reg         expire
);

	reg  [15:0] cnt_ff;
	reg         run_ff;

	assign busy = run_ff;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
			run_ff <= 1'b0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (start) begin
				cnt_ff <= 16'h0001;
				run_ff <= 1'b1;
			end else if (run_ff) begin
				if (cnt_ff == `NVM_PROG_CYC) begin
					run_ff <= 1'b0;
					expire <= 1'b1;
				end
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end

endmodule // nvm_prog_timer

// file: hdl/nvm_write_latch.v
/*
 * Hidden write latches: 64 words, loaded a byte at a time, read a word at
 * a time during commit, cleared to erased value after a write commit, kept after a row erase.
 * Assumes one clock domain with the controller.
 */
`timescale 1ns/10ps
`include "nvm_defs.vh"

module nvm_write_latch (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Byte load
	input  wire        wr_en,
	input  wire [6:0]  byte_idx,
	input  wire [7:0]  wdata,
	// Word read and clear
	input  wire        clr,
	input  wire [5:0]  rd_idx,
	output wire [15:0] rd_word
);

	reg  [15:0] word_ff [0:63];
	integer     i;

	assign rd_word = word_ff[rd_idx];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 64; i = i + 1)
				word_ff[i] <= 16'hffff;
		end else if (clr) begin
			for (i = 0; i < 64; i = i + 1)
				word_ff[i] <= 16'hffff;
		end else if (wr_en) begin
			if (byte_idx[0])
				word_ff[byte_idx[6:1]][15:8] <= wdata;
			else
				word_ff[byte_idx[6:1]][7:0] <= wdata;
		end
	end

endmodule // nvm_write_latch

// file: verif/nvm_core_model.sv
/* Core model: table operations on request, instruction fetches running.
   Assumes the controller shares clk. */
`timescale 1ns/10ps
module nvm_core_model (
	// Clock
	input  wire        clk,
	// Table operations
	output reg         table_read_op,
	output reg         table_write_op,
	output reg  [1:0]  tbl_mode,
	// Fetch
	output reg  [15:0] fetch_addr
);
	initial begin
		table_read_op = 1'b0;
		table_write_op = 1'b0;
		tbl_mode = 2'h0;
		fetch_addr = 16'h0000;
	end
	always @(posedge clk) begin
		fetch_addr <= fetch_addr + 16'h0001;
	end
	// Byte operation at any pointer, any mode
	task op(input is_rd, input [1:0] m);
		begin
			tbl_mode <= m;
			table_read_op <= is_rd;
			table_write_op <= !is_rd;
			@(posedge clk);
			table_read_op <= 1'b0;
			table_write_op <= 1'b0;
			@(posedge clk);
		end
	endtask
endmodule // nvm_core_model

// file: verif/nvm_table_access_control_asserts.sv
/* Checker of the NVM controller ports.
   Assumes binding to the controller top. */
`timescale 1ns/10ps
module nvm_access_asserts (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Watched ports
	input  wire [3:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_rdata,
	input  wire [15:0] fetch_data,
	input  wire        fetch_hold,
	input  wire        prog_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reg        hold_d_ff;
	reg [16:0] hold_len_ff;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_d_ff <= 1'b0;
			hold_len_ff <= 17'h00000;
		end else begin
			hold_d_ff <= fetch_hold;
			if (fetch_hold && !hold_d_ff)
				hold_len_ff <= 17'h00001;
			else if (fetch_hold)
				hold_len_ff <= hold_len_ff + 17'h00001;
		end
	end
	rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	key_reads_zero_a: assert property (reg_rd && reg_addr == 4'h1 |=>
		reg_rdata == 8'h00)
		else $error("unlock key register read nonzero");
	unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h9 |=>
		reg_rdata == 8'h00)
		else $error("unmapped register read nonzero");
	fetch_frozen_a: assert property (fetch_hold && $past(fetch_hold) |->
		$stable(fetch_data))
		else $error("fetch data changed while held");
	hold_min_a: assert property ($fell(fetch_hold) |-> hold_len_ff >= 17'h007d0)
		else $error("programming ended before timer");
	hold_max_a: assert property (fetch_hold |-> hold_len_ff < 17'h11170)
		else $error("programming never ended");
	idle_start_a: assert property (reg_rd && reg_addr == 4'h0 && !fetch_hold |=>
		!reg_rdata[0])
		else $error("start bit set while idle");
	hold_cause_a: assert property ($rose(fetch_hold) |->
		($past(reg_wr) && $past(reg_addr) == 4'h0) || prog_en)
		else $error("hold rose without a start");
endmodule // nvm_access_asserts
bind nvm_table_access_control nvm_access_asserts chk_i (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.fetch_data(fetch_data), .fetch_hold(fetch_hold), .prog_en(prog_en));

// file: verif/nvm_table_access_control_tb.sv
/* Self-checking testbench of the NVM controller.
   Assumes the design, the core model and the checker. */
`timescale 1ns/10ps
module nvm_table_access_control_tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [3:0]  ra = 4'h0;
	reg  [7:0]  rw = 8'h00;
	reg         wr = 1'b0, rd = 1'b0, pe = 1'b0, pw = 1'b0, pr = 1'b0, pb = 1'b0;
	reg  [21:0] pa = 22'h000000, a, p;
	reg  [7:0]  pd = 8'h00, d, v;
	reg  [1:0]  g;
	reg  [31:0] rnd;
	wire [7:0]  rq, pq;
	wire [15:0] fd, fa;
	wire        fh, tro, two;
	wire [1:0]  tm;
	integer     bad_count = 0, comparisons = 0, seed = 54, i;
	always #5 clk = ~clk;
	nvm_table_access_control uut (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wdata(rw),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rq), .table_read_op(tro),
		.table_write_op(two), .tbl_mode(tm), .fetch_addr(fa), .fetch_data(fd),
		.fetch_hold(fh), .prog_en(pe), .prog_addr(pa), .prog_wdata(pd), .prog_wr(pw),
		.prog_rd(pr), .prog_bulk(pb), .prog_rdata(pq));
	nvm_core_model core (.clk(clk), .table_read_op(tro), .table_write_op(two),
		.tbl_mode(tm), .fetch_addr(fa));
	function [7:0] exp_rd(input [1:0] r, input [21:0] x);
		begin
			exp_rd = 8'h00;
			if (r == 2'h2 && x <= 22'h01ffff)
				exp_rd = 8'hff;
			if (r[0] && x >= 22'h200000 && x <= 22'h20000f)
				exp_rd = 8'hff;
		end
	endfunction
	function [21:0] stepped(input [21:0] x, input [1:0] m);
		begin
			stepped = (m == 2'h2) ? x - 22'h1 : (m != 2'h0) ? x + 22'h1 : x;
		end
	endfunction
	task chk(input [95:0] nm, input [7:0] e, input [7:0] s);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("FAIL %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("Comparisons %0d mismatches %0d", comparisons, bad_count);
			if (bad_count == 0 && comparisons > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task cyc(input integer n);
		begin
			wr <= 1'b0;
			rd <= 1'b0;
			repeat (n) @(posedge clk);
		end
	endtask
	task rg_wr(input [3:0] x, input [7:0] y);
		begin
			ra <= x;
			rw <= y;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rg_rd(input [3:0] x);
		begin
			ra <= x;
			rd <= 1'b1;
			wr <= 1'b0;
			@(posedge clk);
			rd <= 1'b0;
			@(posedge clk);
			v = rq;
		end
	endtask
	task setp(input [21:0] x);
		begin
			rg_wr(4'h3, x[7:0]);
			rg_wr(4'h4, x[15:8]);
			rg_wr(4'h5, {2'h0, x[21:16]});
		end
	endtask
	task start(input [7:0] c);
		begin
			rg_wr(4'h0, c);
			rg_wr(4'h1, 8'h55);
			rg_wr(4'h1, 8'haa);
			rg_wr(4'h0, c | 8'h01);
		end
	endtask
	task wait_idle(input integer lim);
		integer n;
		begin
			n = 0;
			cyc(1);
			while (fh === 1'b1 && n < lim) begin
				@(posedge clk);
				n = n + 1;
			end
			chk("idle", 8'h01, {7'h0, n < lim});
		end
	endtask
	task prog_read(input [21:0] x);
		begin
			pa <= x;
			pe <= 1'b1;
			pr <= 1'b1;
			cyc(7);
			v = pq;
			pr <= 1'b0;
			pe <= 1'b0;
		end
	endtask
	task tbl_read(input [1:0] r, input [21:0] x);
		begin
			rg_wr(4'h0, {r, 6'h00});
			setp(x);
			core.op(1'b1, 2'h0);
			rg_rd(4'h2);
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		pe <= 1'b1;
		pb <= 1'b1;
		cyc(8);
		chk("bulk_hold", 8'h01, {7'h0, fh});
		pb <= 1'b0;
		wait_idle(70000);
		pe <= 1'b0;
		cyc(2);
		chk("fetch_word", 8'hff, fd[15:8] & fd[7:0]);
		rg_rd(4'hc);
		chk("unmapped", 8'h00, v);
		rg_rd(4'h1);
		chk("key_zero", 8'h00, v);
		for (i = 0; i < 10; i = i + 1) begin
			rnd = $random(seed);
			case (i)
				0: a = 22'h01ffff;
				1: a = 22'h020000;
				2: a = 22'h200000;
				3: a = 22'h20000f;
				4: a = 22'h200010;
				default: a = rnd[21:0] & 22'h03ffff;
			endcase
			g = (i < 2) ? 2'h2 : (i < 5) ? {rnd[8], 1'b1} : rnd[1:0];
			tbl_read(g, a);
			chk("table_read", exp_rd(g, a), v);
		end
		p = 22'h000010;
		setp(p);
		for (i = 0; i < 4; i = i + 1) begin
			core.op(1'b1, i[1:0]);
			p = stepped(p, i[1:0]);
			rg_rd(4'h3);
			chk("ptr_step", p[7:0], v);
		end
		rnd = $random(seed);
		d = rnd[7:0];
		a = 22'h000400 | {15'h0, rnd[14:8]};
		rg_wr(4'h0, 8'h80);
		setp(a);
		rg_wr(4'h2, d);
		core.op(1'b0, 2'h0);
		tbl_read(2'h2, a);
		chk("latch_only", 8'hff, v);
		start(8'h82);
		cyc(1);
		chk("fetch_hold", 8'h01, {7'h0, fh});
		wait_idle(3000);
		cyc(20);
		rg_rd(4'h9);
		chk("done_flag", 8'h01, v & 8'h03);
		rg_rd(4'h0);
		chk("ctl_end", 8'h00, v & 8'h05);
		tbl_read(2'h2, a);
		chk("flash_byte", d, v);
		tbl_read(2'h2, a ^ 22'h000001);
		chk("flash_peer", 8'hff, v);
		prog_read(a);
		chk("prog_open", d, v);
		rg_wr(4'h9, 8'h00);
		rg_rd(4'h9);
		chk("done_clear", 8'h00, v & 8'h01);
		rg_wr(4'h0, 8'h82);
		rg_wr(4'h0, 8'h83);
		cyc(2);
		rg_rd(4'h0);
		chk("no_unlock", 8'h00, v & 8'h01);
		rg_wr(4'h0, 8'h40);
		setp(22'h250000);
		start(8'h42);
		cyc(2);
		rg_rd(4'h0);
		chk("bad_target", 8'h04, v & 8'h05);
		setp(22'h300008);
		rg_wr(4'h2, 8'hfe);
		start(8'h42);
		wait_idle(3000);
		prog_read(a);
		chk("prog_locked", 8'h00, v);
		tbl_read(2'h2, a);
		chk("self_read", d, v);
		start(8'h8a);
		wait_idle(3000);
		tbl_read(2'h2, a);
		chk("row_erase", 8'hff, v);
		setp(22'h300007);
		rg_wr(4'h2, 8'hf0);
		start(8'h42);
		wait_idle(3000);
		setp(a);
		start(8'h82);
		cyc(2);
		rg_rd(4'h0);
		chk("wr_locked", 8'h04, v & 8'h05);
		print_verdict;
	end
	initial begin
		repeat (90000) @(posedge clk);
		bad_count = bad_count + 1;
		print_verdict;
	end
endmodule // nvm_table_access_control_tb
